//--- logic/bsl_regs.vh
`ifndef BSL_REGS_VH
`define BSL_REGS_VH
// ----------------------------------------
// Serial memory commands and layout
// ----------------------------------------
`define BSL_CMD_READ 8'h03
`define BSL_IMG_BASE 24'h000000
`define BSL_SECTOR_BYTES 24'h000100
`define BSL_TRL_CSUM 8'hFC
`define BSL_TRL_COUNT 8'hFD
`define BSL_MAGIC0 8'hA5
`define BSL_MAGIC1 8'h5A
`define BSL_MAX_SECTORS 8'h80
`define BSL_RAM_AW 15
// ----------------------------------------
// Rates and timing
// ----------------------------------------
`define BSL_CLK_HZ 20000000
`define BSL_SCK_DIV 4
`define BSL_OSC_SETTLE 4096
`define BSL_WDOG_CYCLES 20000000
// ----------------------------------------
// Serial rate selection
// ----------------------------------------
`define BSL_RATE_115200 2'h0
`define BSL_RATE_9600 2'h1
`define BSL_RATE_19200 2'h2
`define BSL_RATE_38400 2'h3
// ----------------------------------------
// Boot status pin codes (led, aux)
// ----------------------------------------
`define BSL_STAT_BUSY 2'h1
`define BSL_STAT_FAIL 2'h2
`define BSL_STAT_LINK 2'h3
`define BSL_STAT_IDLE 2'h0
`endif

//--- logic/bsl_spi_byte.v
`include "bsl_regs.vh"
module bsl_spi_byte (
	input wire clk,
	input wire resetn,
	input wire start,
	input wire [7:0] txByte,
	input wire misoSync,
	output reg sck_r,
	output reg mosi_r,
	output reg [7:0] rxByte_r,
	output reg done_r,
	output reg busy_r
);
	// ----------------------------------------
	// Mode 0 byte shifter, sck derived by a divider enable
	// ----------------------------------------
	reg [1:0] div_r;
	reg [3:0] bitCnt_r;
	reg [7:0] shift_r;
	wire tick = (div_r == 2'h3);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= 2'h0;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			sck_r <= 1'b0;
			mosi_r <= 1'b0;
			rxByte_r <= 8'h00;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			div_r <= busy_r ? div_r + 2'h1 : 2'h0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				shift_r <= txByte;
				mosi_r <= txByte[7];
				bitCnt_r <= 4'h0;
			end else if (busy_r && tick) begin
				if (!sck_r) begin
					sck_r <= 1'b1;
					shift_r <= {shift_r[6:0], misoSync};
				end else begin
					sck_r <= 1'b0;
					mosi_r <= shift_r[7];
					if (bitCnt_r == 4'h7) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
						rxByte_r <= shift_r;
					end
					bitCnt_r <= bitCnt_r + 4'h1;
				end
			end
		end
	end
endmodule

//--- logic/bsl_boot_loader.v
`include "bsl_regs.vh"
module bsl_boot_loader #(
	parameter OSC_SETTLE = `BSL_OSC_SETTLE,
	parameter WDOG_CYCLES = `BSL_WDOG_CYCLES
) (
	input wire clk,
	input wire resetn,
	input wire reset_pin_n,
	input wire porLow,
	input wire oscIn,
	input wire wdogKick,
	input wire boot_source_select,
	input wire upload_strap_pin,
	input wire rate_strap_low,
	input wire rate_strap_high,
	input wire spiMiso,
	output reg spiCsN_r,
	output reg spiSck_r,
	output reg spiMosi_r,
	output reg boot_status_led_pin_r,
	output reg boot_status_led_pin_oe_r,
	output reg boot_status_aux_pin_r,
	output reg boot_status_aux_pin_oe_r,
	output reg pinsReleased_r,
	output reg hardReset_r,
	output reg cpuRun_r,
	output reg linkBoot_r,
	output reg oscEnable_r,
	output reg [1:0] rateSel_r,
	output reg ramWe_r,
	output reg [14:0] ramAddr_r,
	output reg [7:0] ramData_r
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_RESET = 4'h0;
	localparam S_SETTLE = 4'h1;
	localparam S_STRAP = 4'h2;
	localparam S_FIND = 4'h3;
	localparam S_FCHK = 4'h4;
	localparam S_COPY = 4'h5;
	localparam S_CHECK = 4'h6;
	localparam S_RUN = 4'h7;
	localparam S_FAIL = 4'h8;
	localparam S_LINK = 4'h9;
	localparam S_ABORT = 4'hA;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [7:0] sync1_r;
	reg [7:0] sync2_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= {oscIn, reset_pin_n, porLow, boot_source_select,
				upload_strap_pin, rate_strap_low, rate_strap_high, spiMiso};
			sync2_r <= sync1_r;
		end
	end
	wire misoS = sync2_r[0];
	wire rateHiS = sync2_r[1];
	wire rateLoS = sync2_r[2];
	wire strapS = sync2_r[3];
	wire srcS = sync2_r[4];
	wire porS = sync2_r[5];
	wire pinS = sync2_r[6];
	wire oscS = sync2_r[7];

	// ----------------------------------------
	// Hard reset sources
	// ----------------------------------------
	reg [31:0] wdog_r;
	reg oscPrev_r;
	reg [12:0] oscCnt_r;
	wire wdogExpired = cpuRun_r && (wdog_r >= WDOG_CYCLES - 1);
	wire hardReq = !pinS || porS || wdogExpired;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hardReset_r <= 1'b1;
			wdog_r <= 32'h0;
			oscPrev_r <= 1'b0;
			oscCnt_r <= 13'h0;
			oscEnable_r <= 1'b0;
		end else begin
			hardReset_r <= hardReq;
			oscPrev_r <= oscS;
			// Counting survives pin resets; only power loss restarts it.
			if (porS) begin
				oscCnt_r <= 13'h0;
				oscEnable_r <= 1'b0;
			end else if (oscS && !oscPrev_r && !oscEnable_r) begin
				oscCnt_r <= oscCnt_r + 13'h1;
				if (oscCnt_r >= OSC_SETTLE - 1)
					oscEnable_r <= 1'b1;
			end
			if (!cpuRun_r || wdogKick || hardReq)
				wdog_r <= 32'h0;
			else
				wdog_r <= wdog_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Serial memory engine
	// ----------------------------------------
	reg [3:0] state_r;
	reg [2:0] phase_r;
	reg [23:0] addr_r;
	reg [7:0] sector_r;
	reg [7:0] sum_r;
	reg [7:0] storedSum_r;
	reg [7:0] count_r;
	reg [7:0] magic0_r;
	reg start_r;
	reg [7:0] tx_r;
	wire sck;
	wire mosi;
	wire [7:0] rx;
	wire done;
	wire busy;

	bsl_spi_byte uShift (
		.clk(clk),
		.resetn(resetn),
		.start(start_r),
		.txByte(tx_r),
		.misoSync(misoS),
		.sck_r(sck),
		.mosi_r(mosi),
		.rxByte_r(rx),
		.done_r(done),
		.busy_r(busy)
	);

	// Selects the header byte for a given phase of a read command.
	function [7:0] hdrByte;
		input [2:0] ph;
		input [23:0] a;
		begin
			if (ph == 3'h0)
				hdrByte = `BSL_CMD_READ;
			else if (ph == 3'h1)
				hdrByte = a[23:16];
			else if (ph == 3'h2)
				hdrByte = a[15:8];
			else
				hdrByte = a[7:0];
		end
	endfunction

	wire [23:0] imageEnd = {count_r, 8'h00} - 24'h4;
	wire abortReq = strapS && state_r != S_RUN && state_r != S_RESET
		&& state_r != S_SETTLE && state_r != S_FAIL;

	// ----------------------------------------
	// Loader sequence
	// ----------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= S_RESET;
			phase_r <= 3'h0;
			addr_r <= 24'h0;
			sector_r <= 8'h00;
			sum_r <= 8'h00;
			storedSum_r <= 8'h00;
			count_r <= 8'h00;
			magic0_r <= 8'h00;
			start_r <= 1'b0;
			tx_r <= 8'h00;
			spiCsN_r <= 1'b1;
			rateSel_r <= `BSL_RATE_115200;
			cpuRun_r <= 1'b0;
			linkBoot_r <= 1'b0;
			ramWe_r <= 1'b0;
			ramAddr_r <= 15'h0;
			ramData_r <= 8'h00;
		end else begin
			start_r <= 1'b0;
			ramWe_r <= 1'b0;
			// RAM is only written by the copy; reset never clears it.
			if (hardReq) begin
				state_r <= S_RESET;
				cpuRun_r <= 1'b0;
				linkBoot_r <= 1'b0;
				spiCsN_r <= 1'b1;
			end else if (abortReq) begin
				state_r <= S_ABORT;
				spiCsN_r <= 1'b1;
				linkBoot_r <= 1'b0;
			end else begin
				case (state_r)
				S_RESET: begin
					state_r <= S_SETTLE;
				end
				S_SETTLE: begin
					if (oscEnable_r)
						state_r <= S_STRAP;
				end
				S_STRAP: begin
					rateSel_r <= {rateHiS, rateLoS};
					sum_r <= 8'h00;
					sector_r <= 8'h00;
					if (strapS)
						state_r <= S_ABORT;
					else if (srcS) begin
						state_r <= S_FIND;
						addr_r <= {16'h0000, `BSL_TRL_CSUM};
						phase_r <= 3'h0;
					end else begin
						state_r <= S_LINK;
						linkBoot_r <= 1'b1;
					end
				end
				S_FIND, S_COPY: begin
					if (phase_r < 3'h4) begin
						spiCsN_r <= 1'b0;
						if (!busy && !start_r && !done) begin
							tx_r <= hdrByte(phase_r, addr_r);
							start_r <= 1'b1;
						end else if (done)
							phase_r <= phase_r + 3'h1;
					end else if (!busy && !start_r && !done) begin
						tx_r <= 8'h00;
						start_r <= 1'b1;
					end else if (done) begin
						addr_r <= addr_r + 24'h1;
						if (state_r == S_COPY) begin
							ramWe_r <= 1'b1;
							ramAddr_r <= addr_r[14:0];
							ramData_r <= rx;
							sum_r <= sum_r + rx;
							if (addr_r == imageEnd - 24'h1) begin
								spiCsN_r <= 1'b1;
								state_r <= S_CHECK;
							end
						end else begin
							phase_r <= phase_r + 3'h1;
							if (phase_r == 3'h4)
								storedSum_r <= rx;
							else if (phase_r == 3'h5)
								count_r <= rx;
							else if (phase_r == 3'h6)
								magic0_r <= rx;
							else begin
								spiCsN_r <= 1'b1;
								state_r <= S_FCHK;
							end
						end
					end
				end
				S_FCHK: begin
					phase_r <= 3'h0;
					if (magic0_r == `BSL_MAGIC0 && rx == `BSL_MAGIC1
						&& count_r == sector_r + 8'h1) begin
						state_r <= S_COPY;
						addr_r <= `BSL_IMG_BASE;
					end else if (sector_r == `BSL_MAX_SECTORS - 8'h1)
						state_r <= S_FAIL;
					else begin
						state_r <= S_FIND;
						sector_r <= sector_r + 8'h1;
						addr_r <= {8'h00, sector_r + 8'h1, `BSL_TRL_CSUM};
					end
				end
				S_CHECK: begin
					if (sum_r == storedSum_r) begin
						state_r <= S_RUN;
						cpuRun_r <= 1'b1;
					end else
						state_r <= S_FAIL;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	reg [1:0] stat;
	always @* begin
		if (state_r == S_FAIL || state_r == S_ABORT)
			stat = `BSL_STAT_FAIL;
		else if (state_r == S_LINK)
			stat = `BSL_STAT_LINK;
		else if (state_r == S_RUN)
			stat = `BSL_STAT_IDLE;
		else
			stat = `BSL_STAT_BUSY;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spiSck_r <= 1'b0;
			spiMosi_r <= 1'b0;
			boot_status_led_pin_r <= 1'b0;
			boot_status_aux_pin_r <= 1'b0;
			boot_status_led_pin_oe_r <= 1'b1;
			boot_status_aux_pin_oe_r <= 1'b1;
			pinsReleased_r <= 1'b0;
		end else begin
			// A deselect can land mid-byte, so the pin clock is held low.
			spiSck_r <= sck && !spiCsN_r && !hardReq && !abortReq;
			spiMosi_r <= mosi;
			boot_status_led_pin_r <= stat[1];
			boot_status_aux_pin_r <= stat[0];
			boot_status_led_pin_oe_r <= (state_r != S_RUN);
			boot_status_aux_pin_oe_r <= (state_r != S_RUN);
			pinsReleased_r <= (state_r == S_RUN);
		end
	end
endmodule

//--- bench/bsl_flash_model.sv
module bsl_flash_model (
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi,
	output logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cells [0:1023];
	logic [31:0] sh;
	int bc;
	initial miso = 1'h0;
	// A deselected part floats, so show the inverse of the last bit.
	always @(posedge csN) miso <= ~miso;
	always @(negedge csN) bc = 0;
	always @(posedge sck) begin
		if (!csN) begin
			if (bc < 32) sh = {sh[30:0], mosi};
			bc = bc + 1;
		end
	end
	// Only the read command returns data, from the given address on.
	always @(negedge sck) begin
		if (!csN && bc >= 32 && sh[31:24] == 8'h03) begin
			miso <= cells[(sh[9:0] + (bc - 32) / 8) % 1024][7 - (bc - 32) % 8];
		end
	end
endmodule

//--- bench/bsl_boot_loader_sva.sv
`include "bsl_regs.vh"
module bsl_boot_loader_sva (
	input wire clk,
	input wire resetn,
	input wire reset_pin_n,
	input wire upload_strap_pin,
	input wire spiCsN_r,
	input wire spiSck_r,
	input wire boot_status_led_pin_r,
	input wire boot_status_led_pin_oe_r,
	input wire boot_status_aux_pin_r,
	input wire boot_status_aux_pin_oe_r,
	input wire pinsReleased_r,
	input wire hardReset_r,
	input wire cpuRun_r,
	input wire linkBoot_r,
	input wire [1:0] rateSel_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire [1:0] stat = {boot_status_led_pin_r, boot_status_aux_pin_r};
	wire oeBoth = boot_status_led_pin_oe_r && boot_status_aux_pin_oe_r;
	wire oeNone = !boot_status_led_pin_oe_r && !boot_status_aux_pin_oe_r;
	sequence s_load_strap;
		!spiCsN_r ##1 upload_strap_pin [*3];
	endsequence
	sequence s_pin_low;
		!reset_pin_n [*4];
	endsequence
	a_strap_abort: assert property (
		s_load_strap |-> ##[0:8] stat == `BSL_STAT_FAIL)
		else $error("strap did not abort");
	a_pin_reset: assert property (s_pin_low |-> hardReset_r)
		else $error("no hard reset from pin");
	a_run_release: assert property (
		cpuRun_r [*2] |-> pinsReleased_r && oeNone)
		else $error("pins kept after run");
	a_boot_drive: assert property (!cpuRun_r [*2] |-> oeBoth)
		else $error("status pins not driven");
	a_rate_hold: assert property (
		cpuRun_r [*2] |-> $stable(rateSel_r))
		else $error("rate changed");
	a_link_idle: assert property (
		linkBoot_r [*2] |-> spiCsN_r && stat == `BSL_STAT_LINK)
		else $error("link boot state wrong");
	a_mode_idle: assert property (spiCsN_r |-> !spiSck_r)
		else $error("clock moved while deselected");
	a_no_early_run: assert property (hardReset_r |=> !cpuRun_r)
		else $error("run during hard reset");
endmodule
bind bsl_boot_loader bsl_boot_loader_sva chk (.clk, .resetn,
	.reset_pin_n, .upload_strap_pin, .spiCsN_r, .spiSck_r,
	.boot_status_led_pin_r, .boot_status_led_pin_oe_r,
	.boot_status_aux_pin_r, .boot_status_aux_pin_oe_r,
	.pinsReleased_r, .hardReset_r, .cpuRun_r, .linkBoot_r, .rateSel_r);

//--- bench/bsl_boot_loader_bench.sv
`include "bsl_regs.vh"
module bsl_boot_loader_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, resetn = 1'h0, pinN = 1'h1, por = 1'h0, osc = 1'h0;
	logic kick = 1'h0, src = 1'h1, upl = 1'h0, rl = 1'h0, rh = 1'h0;
	wire csN, sck, mosi, miso, led, ledOe, aux, auxOe, rel, hr, run, lnk, we;
	wire oscEn;
	wire [1:0] rate;
	wire [14:0] addr;
	wire [7:0] data;
	wire [23:0] wr = {1'h0, addr, data};
	logic [1:0] r;
	logic [1:0] rateOf [4] = '{`BSL_RATE_115200, `BSL_RATE_9600,
		`BSL_RATE_19200, `BSL_RATE_38400};
	logic [23:0] q [$];
	int err_total = 0, samples_checked = 0;
	always #25 clk = ~clk;
	always #200 osc = ~osc;
	// Shortened settle and watchdog counts keep the run brief.
	bsl_boot_loader #(.OSC_SETTLE(4), .WDOG_CYCLES(200)) dut (
		.clk(clk), .resetn(resetn), .reset_pin_n(pinN), .porLow(por),
		.oscIn(osc), .wdogKick(kick), .boot_source_select(src),
		.upload_strap_pin(upl), .rate_strap_low(rl), .rate_strap_high(rh),
		.spiMiso(miso), .spiCsN_r(csN), .spiSck_r(sck), .spiMosi_r(mosi),
		.boot_status_led_pin_r(led), .boot_status_led_pin_oe_r(ledOe),
		.boot_status_aux_pin_r(aux), .boot_status_aux_pin_oe_r(auxOe),
		.pinsReleased_r(rel), .hardReset_r(hr), .cpuRun_r(run),
		.linkBoot_r(lnk), .oscEnable_r(oscEn), .rateSel_r(rate), .ramWe_r(we),
		.ramAddr_r(addr), .ramData_r(data));
	bsl_flash_model flash (.csN(csN), .sck(sck), .mosi(mosi), .miso(miso));
	task automatic chk(input string w, input logic [23:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", w, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	always @(posedge clk) begin
		if (we === 1'h1) begin
			if (q.size() == 0) chk("extra write", 24'hFFFFFF, wr);
			else chk("ram write", q.pop_front(), wr);
		end
	end
	task automatic load(input int n, input logic s, bad);
		int t;
		logic [7:0] sum;
		t = (n + 259) / 256 * 256 - 4;
		sum = 8'h00;
		q.delete();
		for (int i = 0; i < 1024; i++) begin
			flash.cells[i] = (i < n) ? 8'($urandom) : 8'h00;
			sum += flash.cells[i];
			if (s && i < t) q.push_back({1'h0, i[14:0], flash.cells[i]});
		end
		flash.cells[t] = sum + bad;
		flash.cells[t + 1] = 8'((t + 4) / 256);
		flash.cells[t + 2] = 8'hA5;
		flash.cells[t + 3] = 8'h5A;
		resetn = 1'h0;
		src = s;
		upl = 1'h0;
		{rh, rl} = 2'($urandom);
		tick(20);
		resetn = 1'h1;
	endtask
	task automatic finish();
		int w;
		for (w = 0; w < 40000; w++) begin
			if (run === 1'h1 || lnk === 1'h1) break;
			if ({led, aux} === `BSL_STAT_FAIL) break;
			tick(1);
		end
		if (w == 40000) begin
			chk("completion", 24'h1, 24'h0);
			print_verdict();
		end
	endtask
	initial begin
		void'($urandom(32'h08667047));
		load(300, 1'h1, 1'h0);
		finish();
		tick(2);
		chk("cpu run", 24'h1, {23'h0, run});
		chk("pin drive", 24'h0, {22'h0, ledOe, auxOe});
		chk("released", 24'h1, {23'h0, rel});
		chk("copy left", 24'h0, 24'(q.size()));
		r = rateOf[{rh, rl}];
		chk("rate", {22'h0, r}, {22'h0, rate});
		{rh, rl} = ~{rh, rl};
		tick(10);
		chk("rate held", {22'h0, r}, {22'h0, rate});
		repeat (4) begin
			kick = 1'h1;
			tick(1);
			kick = 1'h0;
			tick(100);
		end
		chk("kicked run", 24'h1, {23'h0, run});
		tick(300);
		chk("watchdog run", 24'h0, {23'h0, run});
		load(100, 1'h1, 1'h1);
		finish();
		chk("bad sum", {22'h0, `BSL_STAT_FAIL}, {22'h0, led, aux});
		chk("bad sum run", 24'h0, {23'h0, run});
		load(300, 1'h1, 1'h0);
		tick(3000);
		chk("busy", {22'h0, `BSL_STAT_BUSY}, {22'h0, led, aux});
		upl = 1'h1;
		finish();
		tick(50);
		chk("abort", {22'h0, `BSL_STAT_FAIL}, {22'h0, led, aux});
		chk("abort spi", 24'h1, {23'h0, csN});
		load(100, 1'h0, 1'h0);
		finish();
		tick(2);
		chk("link boot", 24'h1, {23'h0, lnk});
		chk("link", {22'h0, `BSL_STAT_LINK}, {22'h0, led, aux});
		pinN = 1'h0;
		tick(5);
		chk("pin reset", 24'h1, {23'h0, hr});
		pinN = 1'h1;
		por = 1'h1;
		tick(5);
		chk("power reset", 24'h1, {23'h0, hr});
		chk("osc gated", 24'h0, {23'h0, oscEn});
		por = 1'h0;
		tick(10);
		chk("osc early", 24'h0, {23'h0, oscEn});
		tick(50);
		chk("osc on", 24'h1, {23'h0, oscEn});
		print_verdict();
	end
endmodule
